// ==== rtl/mgmt_serial_phy_access.sv ====
// Behaviour
// - Writing the control register launches a cycle and sets busy bit 0.
// - Read result lands in the portal field as busy clears.
// - Suppress bit omits the 32-bit preamble before each frame.
// - Opcode at bit 3: address, write, read-increment, read.
// - Address operation latches the target register address from the portal.
// - Write opcode sends the portal value to the selected target.
// - Read-increment reads the set address plus one, otherwise a plain read.
// - Clause 45 read-increment sends an address frame then a read frame; other accesses one frame, clause 22 address none.
// - Busy clears at cycle end; no new cycle starts while busy.
// - Bit 5 clear picks bus 0; set, bit 2 picks bus 1 or 2.
// - Buses 0 and 1 use clause 22 frames, bus 2 clause 45.
// - Five-bit device field at bit 6 picks one of 32 devices.
// - Five-bit port field at bit 11 picks one of 32 ports.
// - Sixteen-bit field at bit 16 carries register address or data.
// - Done flag sets at each cycle end; software writes zero to clear.
// - Management clock toggles when a free counter hits the half period.
// - Half-period low five bits fixed at 31, upper three programmable.
// - Data changes or is sampled when the counter equals the offset.
`timescale 1ns/1ps
`default_nettype none
module mgmt_serial_phy_access
    import mgmt_pkg::*;
#(
    parameter int ADDR_W = 20
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Completion level
    output logic done_out,
    // Management buses
    output logic [NUM_BUSES-1:0] mdc_out,
    output logic [NUM_BUSES-1:0] mdio_o_out,
    output logic [NUM_BUSES-1:0] mdio_oe_n_out,
    input wire logic [NUM_BUSES-1:0] mdio_i_in
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SHIFT,
        ST_FINISH
    } state_t;

    state_t state_q;
    state_t state_d;
    logic busy_q;
    logic done_q;
    logic supp_q;
    logic c45_q;
    logic [1:0] op_q;
    logic ifsel_q;
    logic [4:0] dev_q;
    logic [4:0] port_q;
    logic [15:0] ad_q;
    logic [15:0] regaddr_q;
    logic [2:0] per_q;
    logic [2:0] off_q;
    logic [63:0] sh_q;
    logic [5:0] cnt_q;
    logic [15:0] rd_q;
    logic second_q;
    logic armed_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic mdc_w;
    logic drive_tick;
    logic sample_tick;

    // Bus decode
    wire logic setup = psel_in & ~penable_in;
    wire logic access = psel_in & penable_in & pready_q;
    wire logic hit_ctrl = (paddr_in == CTRL_OFS[ADDR_W-1:0]);
    wire logic hit_stat = (paddr_in == STAT_OFS[ADDR_W-1:0]);
    wire logic hit_mode = (paddr_in == MODE_OFS[ADDR_W-1:0]);
    wire logic hit_any = hit_ctrl | hit_stat | hit_mode;
    wire logic wr_ctrl = access & pwrite_in & hit_ctrl;
    wire logic wr_stat = access & pwrite_in & hit_stat;
    wire logic wr_mode = access & pwrite_in & hit_mode;

    // Control writes while busy are dropped so the running frame cannot be corrupted
    wire logic launch = wr_ctrl & ~busy_q;
    wire mgmt_op_t new_op = mgmt_op_t'(pwdata_in[CTRL_OP_LSB +: 2]);
    wire logic new_c45 = pwdata_in[CTRL_IFSEL_BIT] & pwdata_in[CTRL_C45_BIT];
    wire logic [15:0] new_ad = pwdata_in[CTRL_AD_LSB +: 16];
    wire logic [15:0] inc_addr = regaddr_q + 16'h0001;
    wire logic op_is_read = op_q[1];
    // Clause 22 carries no address frame, so its setup completes at once
    wire logic no_frame = launch & (new_op == OP_ADDR) & ~new_c45;

    // Bus select
    wire logic [1:0] bus_sel = ~ifsel_q ? 2'd0 : (c45_q ? 2'd2 : 2'd1);

    // Frame composition for the first frame of a cycle
    wire logic [15:0] launch_reg = (new_op == OP_ADDR) ? new_ad :
                                   (new_op == OP_READ_INC) ? inc_addr : regaddr_q;
    wire logic [1:0] c22_op = (new_op == OP_WRITE) ? C22_OP_WR : C22_OP_RD;
    wire logic [1:0] c45_op = (new_op == OP_WRITE) ? C45_OP_WR :
                              (new_op == OP_READ) ? C45_OP_RD : C45_OP_ADDR;
    wire logic [15:0] c45_payload = (new_op == OP_WRITE) ? new_ad :
                                    (new_op == OP_READ) ? 16'hffff : launch_reg;
    wire logic [15:0] c22_payload = (new_op == OP_WRITE) ? new_ad : 16'hffff;
    wire logic [1:0] c45_ta = (new_op[1] & new_op[0]) ? 2'b11 : TA_DRIVE;
    wire logic [1:0] c22_ta = (new_op == OP_WRITE) ? TA_DRIVE : 2'b11;
    // Port field is the PHY address; device field is the clause 45 device
    wire logic [31:0] frame_c22 = {C22_START, c22_op, pwdata_in[CTRL_PORT_LSB +: 5],
                                   launch_reg[4:0], c22_ta, c22_payload};
    wire logic [31:0] frame_c45 = {C45_START, c45_op, pwdata_in[CTRL_PORT_LSB +: 5],
                                   pwdata_in[CTRL_DEV_LSB +: 5], c45_ta, c45_payload};
    wire logic [31:0] first_frame = new_c45 ? frame_c45 : frame_c22;
    // Second frame of a clause 45 read-increment: a read at the new address
    wire logic [31:0] read_frame = {C45_START, C45_OP_RD, port_q, dev_q, 2'b11, 16'hffff};
    wire logic [5:0] start_cnt = pwdata_in[CTRL_SUPP_BIT] ? CNT_START_NOPRE
                                                          : CNT_START_PRE;
    wire logic [5:0] restart_cnt = supp_q ? CNT_START_NOPRE : CNT_START_PRE;
    wire logic needs_second = launch & new_c45 & (new_op == OP_READ_INC);

    // Serial engine status
    wire logic last_bit = sample_tick & (cnt_q == CNT_LAST);
    wire logic cur_read = op_is_read & ~second_q;
    wire logic released = cur_read & (cnt_q >= CNT_RELEASE);
    wire logic drive_en = (state_q == ST_SHIFT) & armed_q & ~released;
    wire logic capture = (state_q == ST_SHIFT) & sample_tick & cur_read
                         & (cnt_q >= CNT_DATA);

    // Input synchronisers and filtered levels
    logic [NUM_BUSES-1:0] sync1_q;
    logic [NUM_BUSES-1:0] sync2_q;
    logic [NUM_BUSES-1:0] sync3_q;
    logic [NUM_BUSES-1:0] filt_q;
    logic [NUM_BUSES-1:0] mdc_q;
    logic [NUM_BUSES-1:0] dout_q;
    logic [NUM_BUSES-1:0] oe_n_q;

    genvar b;
    generate
        for (b = 0; b < NUM_BUSES; b++) begin : g_bus
            wire logic sel_b = (bus_sel == 2'(b));
            always_ff @(posedge clk_sys_in) begin
                if (srst_in) begin
                    sync1_q[b] <= 1'b1;
                    sync2_q[b] <= 1'b1;
                    sync3_q[b] <= 1'b1;
                    filt_q[b] <= 1'b1;
                    mdc_q[b] <= 1'b0;
                    dout_q[b] <= 1'b1;
                    oe_n_q[b] <= 1'b1;
                end else begin
                    sync1_q[b] <= mdio_i_in[b];
                    sync2_q[b] <= sync1_q[b];
                    sync3_q[b] <= sync2_q[b];
                    if (sync2_q[b] == sync3_q[b]) begin
                        filt_q[b] <= sync3_q[b];
                    end
                    mdc_q[b] <= mdc_w;
                    dout_q[b] <= sh_q[63];
                    oe_n_q[b] <= ~(drive_en & sel_b);
                end
            end
        end
    endgenerate

    wire logic rx_bit = filt_q[bus_sel];

    mgmt_clk_div u_div (
        .clk_sys_in(clk_sys_in),
        .srst_in(srst_in),
        .period_hi_in(per_q),
        .offset_in(off_q),
        .mdc_out(mdc_w),
        .drive_tick_out(drive_tick),
        .sample_tick_out(sample_tick)
    );

    // Sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (launch) begin
                    state_d = no_frame ? ST_FINISH : ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (last_bit && !second_q) begin
                    state_d = ST_FINISH;
                end
            end
            ST_FINISH: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            second_q <= 1'b0;
            sh_q <= '1;
            cnt_q <= CNT_START_PRE;
        end else begin
            state_q <= state_d;
            if (launch) begin
                busy_q <= 1'b1;
                second_q <= needs_second;
                sh_q <= pwdata_in[CTRL_SUPP_BIT] ? {first_frame, 32'hffffffff}
                                                 : {32'hffffffff, first_frame};
                cnt_q <= start_cnt;
            end else if (last_bit && second_q) begin
                second_q <= 1'b0;
                sh_q <= supp_q ? {read_frame, 32'hffffffff} : {32'hffffffff, read_frame};
                cnt_q <= restart_cnt;
            end else if (state_q == ST_SHIFT && sample_tick && armed_q) begin
                sh_q <= {sh_q[62:0], 1'b1};
                cnt_q <= cnt_q + 6'h01;
            end
            if (state_q == ST_FINISH) begin
                busy_q <= 1'b0;
            end
        end
    end

    // First bit waits for a drive tick so it is set up before the first rising edge
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            armed_q <= 1'b0;
        end else if (state_q != ST_SHIFT) begin
            armed_q <= 1'b0;
        end else if (drive_tick) begin
            armed_q <= 1'b1;
        end
    end

    // Control fields, register address and read data
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            supp_q <= 1'b0;
            c45_q <= 1'b0;
            op_q <= OP_ADDR;
            ifsel_q <= 1'b0;
            dev_q <= 5'h00;
            port_q <= 5'h00;
            ad_q <= AD_RST;
            regaddr_q <= AD_RST;
            rd_q <= 16'h0000;
        end else begin
            if (launch) begin
                supp_q <= pwdata_in[CTRL_SUPP_BIT];
                c45_q <= pwdata_in[CTRL_C45_BIT];
                op_q <= new_op;
                ifsel_q <= pwdata_in[CTRL_IFSEL_BIT];
                dev_q <= pwdata_in[CTRL_DEV_LSB +: 5];
                port_q <= pwdata_in[CTRL_PORT_LSB +: 5];
                ad_q <= new_ad;
                if (new_op == OP_ADDR || new_op == OP_READ_INC) begin
                    regaddr_q <= launch_reg;
                end
            end
            if (capture) begin
                rd_q <= {rd_q[14:0], rx_bit};
            end
            if (state_q == ST_FINISH && op_is_read) begin
                ad_q <= rd_q;
            end
        end
    end

    // Done flag: a completion in the clearing cycle wins
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            done_q <= 1'b0;
        end else if (state_q == ST_FINISH) begin
            done_q <= 1'b1;
        end else if (wr_stat && !pwdata_in[STAT_DONE_BIT]) begin
            done_q <= 1'b0;
        end
    end

    // Bus configuration
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            per_q <= MODE_PER_RST;
            off_q <= MODE_OFF_RST;
        end else if (wr_mode) begin
            per_q <= pwdata_in[MODE_PER_LSB +: 3];
            off_q <= pwdata_in[MODE_OFF_LSB +: 3];
        end
    end

    // Read mux, registered in the setup cycle; one wait-free access phase
    wire logic [31:0] ctrl_rd = {ad_q, port_q, dev_q, ifsel_q, op_q, c45_q, supp_q, busy_q};
    wire logic [31:0] stat_rd = {30'h0, done_q, busy_q};
    wire logic [31:0] mode_rd = {5'h00, per_q, off_q, 21'h000000};
    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd :
                               hit_mode ? mode_rd : 32'h0;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~hit_any;
            if (setup) begin
                prdata_q <= rd_mux;
            end
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign done_out = done_q;
    assign mdc_out = mdc_q;
    assign mdio_o_out = dout_q;
    assign mdio_oe_n_out = oe_n_q;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    sequence s_released;
        cur_read && cnt_q >= CNT_RELEASE;
    endsequence
    sequence s_read_end;
        state_q == ST_FINISH && op_is_read;
    endsequence

    a_busy_on_launch: assert property (launch |=> busy_q)
        else $error("busy not set after launch");
    a_read_data_ready: assert property (s_read_end |=> !busy_q && ad_q == $past(rd_q))
        else $error("read data not in portal when busy clears");
    a_no_preamble: assert property (launch && pwdata_in[CTRL_SUPP_BIT]
        |=> cnt_q == CNT_START_NOPRE)
        else $error("preamble not suppressed");
    a_addr_latched: assert property (launch && new_op == OP_ADDR
        |=> regaddr_q == $past(new_ad))
        else $error("setup address not taken");
    a_incr_address: assert property (launch && new_op == OP_READ_INC
        |=> regaddr_q == $past(regaddr_q) + 16'h0001)
        else $error("read increment address wrong");
    a_ctrl_locked: assert property (busy_q && wr_ctrl |=> $stable(op_q) && $stable(port_q))
        else $error("control changed during busy cycle");
    a_done_at_end: assert property ($fell(busy_q) |-> done_q)
        else $error("done flag not set at cycle end");
    a_bus_select: assert property (drive_en && !ifsel_q |=> !oe_n_q[0] && oe_n_q[1]
        && oe_n_q[2])
        else $error("wrong bus driven");
    a_read_turnaround: assert property (s_released |=> &oe_n_q)
        else $error("line driven during read turnaround");
    a_reset_idle: assert property (disable iff (1'b0) srst_in |=> !busy_q && &oe_n_q)
        else $error("not idle after reset");

endmodule // mgmt_serial_phy_access
`default_nettype wire

// ==== rtl/mgmt_pkg.sv ====
package mgmt_pkg;

    // Register byte addresses
    localparam logic [19:0] CTRL_OFS = 20'hc8300;
    localparam logic [19:0] STAT_OFS = 20'hc8304;
    localparam logic [19:0] MODE_OFS = 20'hc8308;

    // Access control field positions
    localparam int CTRL_BUSY_BIT = 0;
    localparam int CTRL_SUPP_BIT = 1;
    localparam int CTRL_C45_BIT = 2;
    localparam int CTRL_OP_LSB = 3;
    localparam int CTRL_IFSEL_BIT = 5;
    localparam int CTRL_DEV_LSB = 6;
    localparam int CTRL_PORT_LSB = 11;
    localparam int CTRL_AD_LSB = 16;

    // Status and bus configuration field positions
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int MODE_OFF_LSB = 21;
    localparam int MODE_PER_LSB = 24;

    // Values after reset
    localparam logic [2:0] MODE_PER_RST = 3'h1;
    localparam logic [2:0] MODE_OFF_RST = 3'h0;
    localparam logic [15:0] AD_RST = 16'h0000;

    // Half-period terminal count, low bits fixed
    localparam logic [4:0] PER_LOW_FIXED = 5'h1f;

    // Bit counter marks over preamble plus frame
    localparam logic [5:0] CNT_START_PRE = 6'h00;
    localparam logic [5:0] CNT_START_NOPRE = 6'h20;
    localparam logic [5:0] CNT_RELEASE = 6'h2e;
    localparam logic [5:0] CNT_DATA = 6'h30;
    localparam logic [5:0] CNT_LAST = 6'h3f;

    // Frame field codes
    localparam logic [1:0] C22_START = 2'b01;
    localparam logic [1:0] C45_START = 2'b00;
    localparam logic [1:0] C22_OP_WR = 2'b01;
    localparam logic [1:0] C22_OP_RD = 2'b10;
    localparam logic [1:0] C45_OP_ADDR = 2'b00;
    localparam logic [1:0] C45_OP_WR = 2'b01;
    localparam logic [1:0] C45_OP_RD = 2'b11;
    localparam logic [1:0] TA_DRIVE = 2'b10;

    localparam int NUM_BUSES = 3;

    typedef enum logic [1:0] {
        OP_ADDR = 2'b00,
        OP_WRITE = 2'b01,
        OP_READ_INC = 2'b10,
        OP_READ = 2'b11
    } mgmt_op_t;

endpackage

// ==== rtl/mgmt_clk_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module mgmt_clk_div
    import mgmt_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic srst_in,
    // Settings
    input wire logic [2:0] period_hi_in,
    input wire logic [2:0] offset_in,
    // Management clock and data ticks
    output logic mdc_out,
    output logic drive_tick_out,
    output logic sample_tick_out
);

    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic mdc_q;
    wire logic [7:0] term = {period_hi_in, PER_LOW_FIXED};
    wire logic at_term = (cnt_q == term);
    wire logic at_offset = (cnt_q == {5'h00, offset_in});

    assign cnt_d = at_term ? 8'h00 : cnt_q + 8'h01;

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            cnt_q <= 8'h00;
            mdc_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            if (at_term) begin
                mdc_q <= ~mdc_q;
            end
        end
    end

    // Drive in the low half, sample in the high half
    assign mdc_out = mdc_q;
    assign drive_tick_out = at_offset & ~mdc_q;
    assign sample_tick_out = at_offset & mdc_q;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    a_mdc_toggles_term: assert property (at_term |=> mdc_q != $past(mdc_q))
        else $error("management clock did not toggle at terminal count");
    a_cnt_wraps_zero: assert property (at_term |=> cnt_q == 8'h00)
        else $error("counter did not return to zero");
    a_low_bits_fixed: assert property (at_term |-> cnt_q[4:0] == 5'h1f)
        else $error("terminal count low bits not 31");
    a_tick_at_offset: assert property ((drive_tick_out || sample_tick_out)
        |-> cnt_q[2:0] == offset_in && cnt_q[7:3] == 5'h00)
        else $error("data tick away from programmed offset");

endmodule // mgmt_clk_div
`default_nettype wire

// ==== sim/mgmt_phy_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mgmt_phy_model (
    // Management bus
    input wire logic mdc_in,
    input wire logic mdio_in,
    input wire logic oe_n_in,
    output logic mdio_out,
    // Bench view
    input wire logic [15:0] rd_data_in,
    output logic [31:0] frame_out,
    output logic [15:0] nbits_out
);
    logic [4:0] slot_q;
    logic [15:0] burst_q;
    logic drv_q;
    initial begin
        mdio_out = 1'b1;
        frame_out = 32'h0000_0000;
        nbits_out = 16'h0000;
        burst_q = 16'h0000;
        drv_q = 1'b0;
        slot_q = 5'h12;
    end
    // Bits are taken on the rising clock edge while the controller drives
    always @(posedge mdc_in) begin
        if (!oe_n_in) begin
            frame_out <= {frame_out[30:0], mdio_in};
            nbits_out <= nbits_out + 16'h0001;
            burst_q <= drv_q ? burst_q + 16'h0001 : 16'h0001;
        end
        drv_q <= !oe_n_in;
    end
    // Answer only after a read header; changes on the falling edge, far from sampling
    always @(negedge mdc_in) begin
        if (!oe_n_in) begin
            slot_q <= 5'h00;
            mdio_out <= 1'b1;
        end else if (slot_q < 5'h12 && burst_q[4:0] == 5'h0e && frame_out[11]) begin
            // First turnaround bit stays released, then a zero, then data MSB first
            mdio_out <= (slot_q == 5'h00) ? 1'b1 : (slot_q == 5'h01) ? 1'b0
                                                  : rd_data_in[5'h11 - slot_q];
            slot_q <= slot_q + 5'h01;
        end else begin
            // Released line floats high through the pull-up
            mdio_out <= 1'b1;
            slot_q <= 5'h12;
        end
    end
endmodule // mgmt_phy_model
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) begin \
            errors++; \
            $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module tb_top;
    import mgmt_pkg::*;
    localparam logic [15:0] PHY_VAL [3] = '{16'h9a3c, 16'h4e71, 16'hd2b8};
    logic clk_sys_in, srst_in, psel, penable, pwrite;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, done, err;
    logic [2:0] mdc, mdio_o, mdio_oe_n;
    wire logic [2:0] mdio_i, phy_drv;
    wire logic [31:0] frm [3];
    wire logic [15:0] nb [3];
    logic [15:0] base, b0;
    int errors, tests_run, i;
    mgmt_serial_phy_access u_mgmt_serial_phy_access (.clk_sys_in(clk_sys_in),
        .srst_in(srst_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .done_out(done), .mdc_out(mdc), .mdio_o_out(mdio_o),
        .mdio_oe_n_out(mdio_oe_n), .mdio_i_in(mdio_i));
    for (genvar b = 0; b < NUM_BUSES; b++) begin : g_phy
        assign mdio_i[b] = (mdio_oe_n[b] ? 1'b1 : mdio_o[b]) & phy_drv[b];
        mgmt_phy_model u_phy (.mdc_in(mdc[b]), .mdio_in(mdio_i[b]), .oe_n_in(mdio_oe_n[b]),
            .mdio_out(phy_drv[b]), .rd_data_in(PHY_VAL[b]), .frame_out(frm[b]),
            .nbits_out(nb[b]));
    end
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task automatic tally_and_finish();
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_sys_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys_in);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            errors++;
            tally_and_finish();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Poll status only; the portal is off limits while busy
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, STAT_OFS, 32'h0);
            n++;
        end while (rd[STAT_BUSY_BIT] !== 1'b0 && n < 5000);
        if (n >= 5000) begin
            errors++;
            tally_and_finish();
        end
    endtask
    task automatic launch(input logic [31:0] cw, input logic frame);
        apb(1'b1, CTRL_OFS, cw);
        apb(1'b0, STAT_OFS, 32'h0);
        if (frame) `CHK(rd[STAT_BUSY_BIT], 1'b1)
        wait_idle();
    endtask
    function automatic logic [31:0] cw(input logic [15:0] ad, input logic [4:0] port,
        input logic [4:0] dev, input logic ifsel, input logic [1:0] op, input logic c45,
        input logic supp);
        return {ad, port, dev, ifsel, op, c45, supp, 1'b0};
    endfunction
    task automatic mdc_period(input int exp);
        int n, k;
        logic p;
        k = 0;
        p = mdc[0];
        for (n = 0; n < 600 && k < 2; n++) begin
            @(posedge clk_sys_in);
            if (mdc[0] === 1'b1 && p === 1'b0) begin
                if (k == 1) `CHK(n, exp)
                k++;
                n = 0;
            end
            p = mdc[0];
        end
        if (k < 2) begin
            errors++;
            tally_and_finish();
        end
    endtask
    initial begin
        errors = 0;
        tests_run = 0;
        srst_in = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 20'h00000;
        pwdata = 32'h0;
        repeat (12) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        `CHK(mdio_oe_n, 3'b111)
        `CHK(done, 1'b0)
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0000_0000)
        apb(1'b0, MODE_OFS, 32'h0);
        `CHK(rd & 32'h07e0_0000, 32'h0100_0000)
        apb(1'b0, 20'hc830c, 32'h0);
        `CHK({err, rd}, {1'b1, 32'h0000_0000})
        mdc_period(128);
        // Shortest legal half period keeps the run brief
        apb(1'b1, MODE_OFS, 32'h0040_0000);
        apb(1'b0, MODE_OFS, 32'h0);
        `CHK(rd & 32'h07e0_0000, 32'h0040_0000)
        mdc_period(64);
        // Bus 0 write, with a stray control write while busy
        launch(cw(16'h0007, 5'h13, 5'h04, 1'b0, OP_ADDR, 1'b0, 1'b0), 1'b0);
        base = nb[0];
        apb(1'b1, CTRL_OFS, cw(16'ha5c3, 5'h13, 5'h04, 1'b0, OP_WRITE, 1'b0, 1'b0));
        apb(1'b1, CTRL_OFS, cw(16'h5555, 5'h02, 5'h01, 1'b1, OP_READ, 1'b1, 1'b1));
        wait_idle();
        `CHK(frm[0], {C22_START, C22_OP_WR, 5'h13, 5'h07, TA_DRIVE, 16'ha5c3})
        `CHK(16'(nb[0] - base), 16'd64)
        `CHK(done, 1'b1)
        apb(1'b1, STAT_OFS, 32'h0000_0002);
        apb(1'b0, STAT_OFS, 32'h0);
        `CHK(rd[1:0], 2'b10)
        apb(1'b1, STAT_OFS, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        `CHK({done, rd[1:0]}, 3'b000)
        // Bus 1 read without preamble
        launch(cw(16'h001e, 5'h0b, 5'h00, 1'b1, OP_ADDR, 1'b0, 1'b1), 1'b0);
        base = nb[1];
        b0 = nb[0];
        launch(cw(16'h0000, 5'h0b, 5'h00, 1'b1, OP_READ, 1'b0, 1'b1), 1'b1);
        `CHK(16'(nb[1] - base), 16'd14)
        `CHK(nb[0], b0)
        `CHK(frm[1][13:0], {C22_START, C22_OP_RD, 5'h0b, 5'h1e})
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd[31:16], PHY_VAL[1])
        // Bus 0 read with increment walks upward
        launch(cw(16'h0005, 5'h13, 5'h04, 1'b0, OP_ADDR, 1'b0, 1'b0), 1'b0);
        for (i = 6; i < 8; i++) begin
            launch(cw(16'h0000, 5'h13, 5'h04, 1'b0, OP_READ_INC, 1'b0, 1'b0), 1'b1);
            `CHK(frm[0][13:0], {C22_START, C22_OP_RD, 5'h13, i[4:0]})
            apb(1'b0, CTRL_OFS, 32'h0);
            `CHK(rd[31:16], PHY_VAL[0])
        end
        // Bus 2 clause 45 address, read, read with increment, write
        launch(cw(16'h1234, 5'h09, 5'h03, 1'b1, OP_ADDR, 1'b1, 1'b0), 1'b1);
        `CHK(frm[2], {C45_START, C45_OP_ADDR, 5'h09, 5'h03, TA_DRIVE, 16'h1234})
        launch(cw(16'h0000, 5'h09, 5'h03, 1'b1, OP_READ, 1'b1, 1'b0), 1'b1);
        `CHK(frm[2][13:0], {C45_START, C45_OP_RD, 5'h09, 5'h03})
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd[31:16], PHY_VAL[2])
        base = nb[2];
        launch(cw(16'h0000, 5'h09, 5'h03, 1'b1, OP_READ_INC, 1'b1, 1'b0), 1'b1);
        `CHK(16'(nb[2] - base), 16'd110)
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd[31:16], PHY_VAL[2])
        launch(cw(16'h0f96, 5'h09, 5'h03, 1'b1, OP_WRITE, 1'b1, 1'b1), 1'b1);
        `CHK(frm[2], {C45_START, C45_OP_WR, 5'h09, 5'h03, TA_DRIVE, 16'h0f96})
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
